// file: hdl/emp_port_ctrl.sv
// Behaviour
// - space select chosen from word address bits 31..28, one per region.
// - at most one space select asserted during any external access.
// - byte lane enables decoded from address bit 0 and the access size.
// - byte lanes act as write enables and as the sdram data mask.
// - clock source select: 0 internal divided clock, 1 the input clock pin.
// - clock gate: 0 holds memory clock low, 1 lets it toggle.
// - host drives hold request; device answers with bus release ack.
// - first strobe: async read, sdram cas, burst sram address strobe.
// - second strobe: async output enable, sdram ras, burst sram output enable.
// - third strobe: write enable for all memory types.
// - async memory drives ready; device samples it during async accesses.
module emp_port_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the on-chip memory controller
  input wire logic acc_req,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire emp_pkg::emp_size_t acc_size,
  input wire logic [7:0] space_mem_type,
  output logic acc_busy,
  output logic acc_done,
  output logic acc_err,
  // clock configuration
  input wire logic mem_clock_source_sel,
  input wire logic mem_clock_gate,
  // external pins
  input wire logic mem_clock_in,
  input wire logic async_ready_in,
  input wire logic hold_req_in,
  output logic mem_clock_out,
  output logic space_select_0_n,
  output logic space_select_1_n,
  output logic space_select_2_n,
  output logic space_select_3_n,
  output logic byte_lane_enable_0_n,
  output logic byte_lane_enable_1_n,
  output logic strobe_read_cas_ads_n,
  output logic strobe_oe_ras_n,
  output logic strobe_write_n,
  output logic ctrl_oe,
  output logic bus_release_ack,
  output logic bus_need_out
);
  import emp_pkg::*;

  // pin synchronisers: bit 0 clock in, bit 1 ready, bit 2 hold
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic clkin_s;
  logic rdy_s;
  logic hold_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {hold_req_in, async_ready_in, mem_clock_in};
      sync2_q <= sync1_q;
    end
  end
  assign clkin_s = sync2_q[0];
  assign rdy_s = sync2_q[1];
  assign hold_s = sync2_q[2];

  // sequencer state
  emp_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] space_q, space_d;
  emp_mem_type_t mt_q, mt_d;
  logic wr_q, wr_d;
  logic [1:0] lanes_q, lanes_d;
  logic done_d, err_d, busy_d, need_d;
  logic [3:0] nib;
  logic [3:0] off;
  logic [1:0] lane_dec;
  emp_mem_type_t req_mt;

  // lane decode: a byte picks one lane by address bit 0, wider uses both
  always_comb begin
    nib = acc_addr[EMP_SPACE_MSB:EMP_SPACE_LSB];
    off = 4'(nib - EMP_SPACE_BASE);
    case (acc_size)
      EMP_SZ_BYTE: lane_dec = acc_addr[0] ? 2'h2 : 2'h1;
      default: lane_dec = 2'h3;
    endcase
    case (off[1:0])
      2'h0: req_mt = emp_mem_type_t'(space_mem_type[1:0]);
      2'h1: req_mt = emp_mem_type_t'(space_mem_type[3:2]);
      2'h2: req_mt = emp_mem_type_t'(space_mem_type[5:4]);
      default: req_mt = emp_mem_type_t'(space_mem_type[7:6]);
    endcase
  end

  // next state of the access sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    space_d = space_q;
    mt_d = mt_q;
    wr_d = wr_q;
    lanes_d = lanes_q;
    done_d = 1'b0;
    err_d = 1'b0;
    need_d = 1'b0;
    case (st_q)
      EMP_ST_IDLE: begin
        // hold wins over a new request so the host is never starved
        if (hold_s) begin
          st_d = EMP_ST_HELD;
        end else if (acc_req) begin
          if (nib >= EMP_SPACE_BASE && off < 4'(EMP_NUM_SPACES)) begin
            space_d = off[1:0];
            mt_d = req_mt;
            wr_d = acc_write;
            lanes_d = lane_dec;
            case (req_mt)
              EMP_MT_ASYNC: begin
                st_d = EMP_ST_SETUP;
                cnt_d = 4'(EMP_SETUP_CYC - 4'h1);
              end
              EMP_MT_SDRAM: st_d = EMP_ST_ACT;
              default: st_d = EMP_ST_CMD;
            endcase
          end else begin
            err_d = 1'b1;
          end
        end
      end
      EMP_ST_SETUP: begin
        if (cnt_q == 4'h0) begin
          st_d = EMP_ST_STROBE;
          cnt_d = 4'(EMP_STROBE_CYC - 4'h1);
        end else begin
          cnt_d = 4'(cnt_q - 4'h1);
        end
      end
      EMP_ST_STROBE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = 4'(cnt_q - 4'h1);
        end else if (rdy_s) begin
          st_d = EMP_ST_HOLD;
          cnt_d = 4'(EMP_HOLD_CYC - 4'h1);
        end
      end
      EMP_ST_HOLD: begin
        if (cnt_q == 4'h0) begin
          st_d = EMP_ST_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = 4'(cnt_q - 4'h1);
        end
      end
      EMP_ST_ACT: st_d = EMP_ST_CMD;
      EMP_ST_CMD: begin
        st_d = EMP_ST_IDLE;
        done_d = 1'b1;
      end
      EMP_ST_HELD: begin
        if (!hold_s) begin
          st_d = EMP_ST_IDLE;
        end
        need_d = acc_req;
      end
      default: st_d = EMP_ST_IDLE;
    endcase
    busy_d = (st_d != EMP_ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= EMP_ST_IDLE;
      cnt_q <= 4'h0;
      space_q <= 2'h0;
      mt_q <= EMP_MT_ASYNC;
      wr_q <= 1'b0;
      lanes_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      space_q <= space_d;
      mt_q <= mt_d;
      wr_q <= wr_d;
      lanes_q <= lanes_d;
    end
  end

  // pin values for the next cycle, taken from the next state
  logic act_d;
  logic [3:0] sel_n_d;
  logic [1:0] lane_n_d;
  logic rd_n_d, oe_n_d, we_n_d;
  logic ack_d, drive_d;

  always_comb begin
    act_d = (st_d != EMP_ST_IDLE) && (st_d != EMP_ST_HELD);
    sel_n_d = 4'hF;
    if (act_d) begin
      sel_n_d[space_d] = 1'b0;
    end
    lane_n_d = act_d ? ~lanes_d : 2'h3;
    rd_n_d = 1'b1;
    oe_n_d = 1'b1;
    we_n_d = 1'b1;
    case (st_d)
      EMP_ST_STROBE: begin
        rd_n_d = wr_d;
        oe_n_d = wr_d;
        we_n_d = !wr_d;
      end
      EMP_ST_ACT: oe_n_d = 1'b0;
      EMP_ST_CMD: begin
        rd_n_d = 1'b0;
        we_n_d = !wr_d;
        // burst sram output enable on reads
        oe_n_d = (mt_d == EMP_MT_SBSRAM) ? wr_d : 1'b1;
      end
      default: ;
    endcase
    ack_d = (st_d == EMP_ST_HELD);
    drive_d = !ack_d;
  end

  // all pins registered so nothing glitches on the board
  logic [3:0] sel_n_q;
  logic [1:0] lane_n_q;
  logic rd_n_q, oe_n_q, we_n_q, ack_q, drive_q, need_q;
  logic busy_q, done_q, err_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_q <= 4'hF;
      lane_n_q <= 2'h3;
      rd_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ack_q <= 1'b0;
      drive_q <= 1'b1;
      need_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      sel_n_q <= sel_n_d;
      lane_n_q <= lane_n_d;
      rd_n_q <= rd_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      ack_q <= ack_d;
      drive_q <= drive_d;
      need_q <= need_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  // memory clock: divided internal clock or the sampled input pin;
  // the pin is oversampled, so its edges jitter by one clk period
  logic [3:0] div_q, div_d;
  logic int_clk_q, int_clk_d;
  logic mclk_q, mclk_d;

  always_comb begin
    div_d = 4'(div_q + 4'h1);
    int_clk_d = int_clk_q;
    if (div_q == 4'(EMP_INTERNAL_SYS_CLOCK_3_HALF - 4'h1)) begin
      div_d = 4'h0;
      int_clk_d = !int_clk_q;
    end
    mclk_d = mem_clock_source_sel ? clkin_s : int_clk_q;
    if (!mem_clock_gate) begin
      mclk_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      int_clk_q <= 1'b0;
      mclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      int_clk_q <= int_clk_d;
      mclk_q <= mclk_d;
    end
  end

  assign space_select_0_n = sel_n_q[0];
  assign space_select_1_n = sel_n_q[1];
  assign space_select_2_n = sel_n_q[2];
  assign space_select_3_n = sel_n_q[3];
  assign byte_lane_enable_0_n = lane_n_q[0];
  assign byte_lane_enable_1_n = lane_n_q[1];
  assign strobe_read_cas_ads_n = rd_n_q;
  assign strobe_oe_ras_n = oe_n_q;
  assign strobe_write_n = we_n_q;
  assign ctrl_oe = drive_q;
  assign bus_release_ack = ack_q;
  assign bus_need_out = need_q;
  assign acc_busy = busy_q;
  assign acc_done = done_q;
  assign acc_err = err_q;
  assign mem_clock_out = mclk_q;

  // checks
  one_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    $countones(~sel_n_q) <= 1) else $error("more than one space select");
  select_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == EMP_ST_IDLE && !hold_s && acc_req && nib == EMP_SPACE_BASE)
    |=> !space_select_0_n) else $error("space select not from address");
  lane_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == EMP_ST_IDLE && !hold_s && acc_req && acc_size == EMP_SZ_BYTE
     && nib >= EMP_SPACE_BASE && off < 4'(EMP_NUM_SPACES) && acc_addr[0])
    |=> (!byte_lane_enable_1_n && byte_lane_enable_0_n)) else $error("bad lane decode");
  lane_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!strobe_write_n || (!strobe_read_cas_ads_n && mt_q == EMP_MT_SDRAM))
    |-> ({byte_lane_enable_1_n, byte_lane_enable_0_n} == ~lanes_q) && (lanes_q != 2'h0))
    else $error("lane enables wrong during access");
  ready_stretch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == EMP_ST_STROBE && cnt_q == 4'h0 && !rdy_s)
    |=> (st_q == EMP_ST_STROBE && !strobe_oe_ras_n == !wr_q)) else $error("strobe ended early");
  clk_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !mem_clock_gate |=> !mem_clock_out) else $error("memory clock not held low");
  clk_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_clock_gate && mem_clock_source_sel) |=> mem_clock_out == $past(clkin_s))
    else $error("memory clock not from input pin");
  hold_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == EMP_ST_IDLE && hold_s) |=> (bus_release_ack && !ctrl_oe && sel_n_q == 4'hF))
    else $error("hold not acknowledged");
  write_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strobe_write_n |-> wr_q) else $error("write strobe on a read");
  async_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!strobe_read_cas_ads_n && mt_q == EMP_MT_ASYNC) |-> (!wr_q && !strobe_oe_ras_n))
    else $error("async read strobe misused");
endmodule

// file: hdl/emp_pkg.sv
package emp_pkg;
  // memory type of each space, as the controller configures it
  typedef enum logic [1:0] {
    EMP_MT_ASYNC = 2'h0,
    EMP_MT_SDRAM = 2'h1,
    EMP_MT_SBSRAM = 2'h2
  } emp_mem_type_t;

  // access size of a request
  typedef enum logic [1:0] {
    EMP_SZ_BYTE = 2'h0,
    EMP_SZ_HALF = 2'h1,
    EMP_SZ_WORD = 2'h2
  } emp_size_t;

  // sequencer states
  typedef enum logic [2:0] {
    EMP_ST_IDLE = 3'h0,
    EMP_ST_SETUP = 3'h1,
    EMP_ST_STROBE = 3'h2,
    EMP_ST_HOLD = 3'h3,
    EMP_ST_ACT = 3'h4,
    EMP_ST_CMD = 3'h5,
    EMP_ST_HELD = 3'h6
  } emp_state_t;

  // space decode: word address bits 31..28, first region code
  localparam int EMP_SPACE_MSB = 31;
  localparam int EMP_SPACE_LSB = 28;
  localparam logic [3:0] EMP_SPACE_BASE = 4'h8;
  localparam int EMP_NUM_SPACES = 4;

  // asynchronous access phases, in clk cycles
  localparam logic [3:0] EMP_SETUP_CYC = 4'h2;
  localparam logic [3:0] EMP_STROBE_CYC = 4'h3;
  localparam logic [3:0] EMP_HOLD_CYC = 4'h1;

  // internal memory clock: half period in clk cycles
  localparam logic [3:0] EMP_INTERNAL_SYS_CLOCK_3_HALF = 4'h2;
endpackage

// file: testbench/emp_far_side.sv
module emp_far_side (
  // pins seen by the memory
  input wire logic clk,
  input wire logic sel_n,
  input wire logic strobe_n,
  // scenario controls
  input wire logic hold_cmd,
  input wire logic [3:0] ready_wait,
  // pins toward the device
  output logic async_ready_in,
  output logic hold_req_in,
  output logic mem_clock_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q = 4'h0;

  // link clock runs free; odd phase keeps its edges off clk edges
  initial begin
    mem_clock_in = 1'b0;
    #37;
    forever #400 mem_clock_in = ~mem_clock_in;
  end

  always @(posedge clk) begin
    if (sel_n) wait_q <= 4'h0;
    else if (!strobe_n && wait_q < ready_wait) wait_q <= wait_q + 4'h1;
  end
  // ready pin: pulled up when unselected, low until the wait is spent
  assign async_ready_in = sel_n | (wait_q >= ready_wait);
  assign hold_req_in = hold_cmd;
endmodule

// file: testbench/ext_memory_port_control_test.sv
module ext_memory_port_control_test import emp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus
  logic clk = 1'b0, rst_n = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
  logic msel = 1'b0, mgate = 1'b1, hold_cmd = 1'b0;
  logic [31:0] acc_addr = 32'h0;
  emp_size_t acc_size = EMP_SZ_WORD;
  logic [7:0] mtype = 8'h00;
  logic [3:0] ready_wait = 4'h0;
  // observed pins and samples
  logic busy, done, err, mco, s0, s1, s2, s3, b0, b1, rd, oe, wr, coe, ack, need;
  logic rdy, hreq, mci, err_t1;
  logic [3:0] sel_t1;
  logic [1:0] lane_t1;
  logic [2:0] strb_t1;
  int fail_count = 0, num_checks = 0, cycles = 0, lat = 0;

  always #50 clk = ~clk;

  emp_port_ctrl uut (.clk(clk), .rst_n(rst_n), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_size(acc_size), .space_mem_type(mtype), .acc_busy(busy),
    .acc_done(done), .acc_err(err), .mem_clock_source_sel(msel), .mem_clock_gate(mgate),
    .mem_clock_in(mci), .async_ready_in(rdy), .hold_req_in(hreq), .mem_clock_out(mco),
    .space_select_0_n(s0), .space_select_1_n(s1), .space_select_2_n(s2),
    .space_select_3_n(s3), .byte_lane_enable_0_n(b0), .byte_lane_enable_1_n(b1),
    .strobe_read_cas_ads_n(rd), .strobe_oe_ras_n(oe), .strobe_write_n(wr), .ctrl_oe(coe),
    .bus_release_ack(ack), .bus_need_out(need));

  emp_far_side far (.clk(clk), .sel_n(s0 & s1 & s2 & s3), .strobe_n(rd & wr),
    .hold_cmd(hold_cmd), .ready_wait(ready_wait), .async_ready_in(rdy),
    .hold_req_in(hreq), .mem_clock_in(mci));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs move 1 ns after the edge so no race with sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one access; pins sampled just after the taking edge, lat counts edges up to done
  task automatic access(input logic [31:0] a, input logic w, input emp_size_t sz);
    acc_addr = a;
    acc_write = w;
    acc_size = sz;
    acc_req = 1'b1;
    tick(1);
    acc_req = 1'b0;
    sel_t1 = {s3, s2, s1, s0};
    lane_t1 = {b1, b0};
    strb_t1 = {rd, oe, wr};
    err_t1 = err;
    lat = 1;
    while (err_t1 !== 1'b1 && done !== 1'b1 && lat < 40) begin
      tick(1);
      lat++;
    end
  endtask

  task automatic t_reset();
    chk({s3, s2, s1, s0, b1, b0, rd, oe}, 8'hFF);
    chk({wr, coe, ack, need, busy, done, err, mco}, 8'hC0);
    $display("test reset done");
  endtask

  // every space, memory type and direction; byte and half sizes
  task automatic t_decode();
    logic [2:0] es;
    for (int sp = 0; sp < 4; sp++) begin
      for (int ty = 0; ty < 3; ty++) begin
        for (int w = 0; w < 2; w++) begin
          mtype = {4{ty[1:0]}};
          access({4'h8 + sp[3:0], 27'h0, sp[0]}, w[0], emp_size_t'({1'b0, sp[1]}));
          es = (ty == 0) ? 3'h7 : (ty == 1) ? 3'h5 : {1'b0, w[0], ~w[0]};
          chk({4'h0, sel_t1}, {4'h0, ~(4'h1 << sp)});
          chk({6'h0, lane_t1}, sp[1] ? 8'h00 : (sp[0] ? 8'h01 : 8'h02));
          chk({5'h0, strb_t1}, {5'h0, es});
          chk(lat[7:0], (ty == 0) ? 8'h07 : (ty == 1) ? 8'h03 : 8'h02);
        end
      end
    end
    $display("test decode done");
  endtask

  // slow memory holds ready low: the strobe must stretch
  task automatic t_ready();
    mtype = 8'h00;
    ready_wait = 4'h4;
    access(32'h9000_0000, 1'b0, EMP_SZ_WORD);
    chk({7'h0, lat > 9 && lat < 16}, 8'h01);
    chk({4'h0, sel_t1}, 8'h0D);
    ready_wait = 4'h0;
    $display("test ready done");
  endtask

  // addresses just outside the mapped spaces
  task automatic t_unmapped();
    for (int i = 0; i < 2; i++) begin
      access(i == 0 ? 32'h7FFF_FFFF : 32'hC000_0000, 1'b1, EMP_SZ_WORD);
      chk({1'b0, err_t1, sel_t1, lane_t1}, 8'h7F);
      tick(1);
    end
    $display("test unmapped done");
  endtask

  task automatic t_hold();
    int n;
    n = 0;
    hold_cmd = 1'b1;
    while (ack !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk({6'h0, n <= 5, ack, coe}, 8'h06);
    acc_addr = 32'h8000_0000;
    acc_req = 1'b1;
    tick(2);
    chk({6'h0, need, busy}, 8'h03);
    acc_req = 1'b0;
    tick(2);
    chk({7'h0, need}, 8'h00);
    hold_cmd = 1'b0;
    n = 0;
    while (ack !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    chk({6'h0, ack, coe}, 8'h01);
    $display("test hold done");
  endtask

  task automatic edges(output int n);
    logic p;
    n = 0;
    p = mco;
    repeat (32) begin
      tick(1);
      if (mco === 1'b1 && p === 1'b0) n++;
      p = mco;
    end
  endtask

  // internal source, pin source, then gated off
  task automatic t_clock();
    int n;
    tick(4);
    edges(n);
    chk(n[7:0], 8'h08);
    msel = 1'b1;
    tick(8);
    edges(n);
    chk(n[7:0], 8'h04);
    mgate = 1'b0;
    tick(8);
    edges(n);
    chk({n[6:0], mco}, 8'h00);
    $display("test clock done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    tick(1);
    t_decode();
    t_ready();
    t_unmapped();
    t_hold();
    t_clock();
    final_report();
  end
endmodule
